// file: sync_pwm_timer.sv
// Notes on behaviour
// RL1 - Synced write loads all synced counters
// RL2 - Sync-clear follows other synced clear
// RL3 - PWM: A match sets, B clears
// RL4 - PWM duty 0% to 100%
// RL5 - Equal A and B: pin unchanged
// RL6 - Clear on B, A above B: low
// RL7 - Clear on A, B above A: high
// RL8 - PWM on any channel, pin output
// RL9 - Channel 2 phase mode counts up/down
// RL10 - Phase mode keeps clear, capture, flags
// RL11 - Quadrature table sets direction
// RL12 - Every phase edge counts; the code counts no step when both phase pins change in the same cycle
// RL13 - Init write drives output levels
// RL14 - Init written only when stopped; the code takes an init write while the counters run as well
// RL15 - Match as counter leaves equal value
// RL16 - Capture copies counter, sets flag
// RL17 - Wrap flag either direction
// RL18 - Flag clear: read one, write zero
// RL19 - Nine request lines, one per flag
// RL20 - Priority channel 0 first, A, B, overflow
// RL21 - A/B request needs flag and enable
// RL22 - Match clear returns to zero, counts on
// RL23 - Match-cleared period is register plus one
//
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none

module sync_pwm_timer #(
    parameter int NCH = 3
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // External clock and phase pins
    input  wire logic        phase_input_a,
    input  wire logic        phase_input_b,
    input  wire logic [1:0]  ext_clk_in,
    // Capture inputs
    input  wire logic [2:0]  capture_in_a,
    input  wire logic [2:0]  capture_in_b,
    // Output pins
    output logic      [2:0]  channel_out_a_pin,
    output logic      [2:0]  channel_out_a_oe,
    // Interrupt requests
    output logic      [2:0]  match_irq_a,
    output logic      [2:0]  match_irq_b,
    output logic      [2:0]  wrap_irq,
    output logic      [3:0]  irq_vector
);

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_READ = 1'b1
    } bus_state_t;

    // Edge select decode
    function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
        edge_hit = (sel == timer_pkg::EDGE_RISE) ? rise :
                   (sel == timer_pkg::EDGE_FALL) ? fall : (rise | fall);
    endfunction

    // Channel block hit for an address
    function automatic logic ch_hit(input logic [7:0] a, input int ch);
        ch_hit = (a[7:4] == (timer_pkg::CH_BLK_FIRST + 4'(ch)));
    endfunction

    // Lowest pending index wins
    function automatic logic [3:0] first_set(input logic [8:0] v);
        logic [3:0] r;
        r = timer_pkg::VEC_NONE;
        for (int i = 8; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        first_set = r;
    endfunction

    bus_state_t   state_q;
    logic [7:0]   addr_q;
    logic         addr_ok_q;
    logic         wr_q;
    logic [31:0]  hrdata_q;
    logic         hreadyout_q;

    logic [2:0]   run_q;
    logic [2:0]   sync_q;
    logic [3:0]   mode_q;
    logic [2:0]   out_q;
    logic [2:0]   oe_q;
    logic [2:0]   en_q   [3];
    logic [2:0]   flag_q [3];
    logic [2:0]   arm_q  [3];
    logic [8:0]   irq_q;
    logic [8:0]   irq_d;
    logic [3:0]   vec_q;
    logic [2:0]   presc_q;
    logic [3:0]   ext_prev_q;
    logic [2:0]   cap_a_prev_q;
    logic [2:0]   cap_b_prev_q;

    logic [15:0]  cnt_q  [3];
    logic [15:0]  gra_q  [3];
    logic [15:0]  grb_q  [3];
    logic [10:0]  ctrl_q [3];

    logic [2:0]   ev_a;
    logic [2:0]   ev_b;
    logic [2:0]   ev_ovf;
    logic [2:0]   own_clr;
    logic [2:0]   cnt_wr_v;
    logic [2:0]   out_d;
    logic [31:0]  ch_rd  [3];

    phase_step_if steps ();

    // Quadrature decoder for channel 2
    phase_decoder u_phase (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .phase_input_a (phase_input_a),
        .phase_input_b (phase_input_b),
        .steps         (steps.src)
    );

    // Bus decode
    wire        take      = hsel & htrans[1] & hready;
    wire        wr_en     = wr_q & addr_ok_q;
    wire        rd_en     = (state_q == BUS_READ) & addr_ok_q;
    wire        wr_run    = wr_en & (addr_q == timer_pkg::OFS_RUN);
    wire        wr_sync   = wr_en & (addr_q == timer_pkg::OFS_SYNC);
    wire        wr_mode   = wr_en & (addr_q == timer_pkg::OFS_MODE);
    wire        wr_init   = wr_en & (addr_q == timer_pkg::OFS_OUT_INIT);
    wire [1:0]  sub       = addr_q[3:2];
    wire [3:0]  ext_now   = {ext_clk_in, phase_input_b, phase_input_a};
    wire        phase_on  = mode_q[timer_pkg::MODE_PHASE_BIT];
    wire        sync_wr   = |(cnt_wr_v & sync_q);
    wire        sync_clr  = |(own_clr & sync_q);

    // Status register offsets by flag kind
    wire [7:0]  stat_ofs [3] = '{timer_pkg::OFS_STAT_A, timer_pkg::OFS_STAT_B, timer_pkg::OFS_STAT_OVF};

    // Read data selection
    wire [31:0] rd_mux =
        (addr_q == timer_pkg::OFS_RUN)      ? {29'h0, run_q} :
        (addr_q == timer_pkg::OFS_SYNC)     ? {29'h0, sync_q} :
        (addr_q == timer_pkg::OFS_MODE)     ? {28'h0, mode_q} :
        (addr_q == timer_pkg::OFS_STAT_A)   ? {25'h0, en_q[0], 1'b0, flag_q[0]} :
        (addr_q == timer_pkg::OFS_STAT_B)   ? {25'h0, en_q[1], 1'b0, flag_q[1]} :
        (addr_q == timer_pkg::OFS_STAT_OVF) ? {25'h0, en_q[2], 1'b0, flag_q[2]} :
        (addr_q == timer_pkg::OFS_OUT_LVL)  ? {29'h0, out_q} :
        ch_hit(addr_q, 0)                   ? ch_rd[0] :
        ch_hit(addr_q, 1)                   ? ch_rd[1] :
        ch_hit(addr_q, 2)                   ? ch_rd[2] : 32'h0000_0000;

    // Bus state, read data, strobes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q     <= BUS_IDLE;
            addr_q      <= 8'h00;
            addr_ok_q   <= 1'b0;
            wr_q        <= 1'b0;
            hrdata_q    <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
        end else begin
            case (state_q)
                BUS_IDLE: begin
                    wr_q <= take & hwrite;
                    if (take) begin
                        addr_q    <= haddr[7:0];
                        addr_ok_q <= (haddr[31:8] == 24'h00_0000) & (haddr[1:0] == 2'b00);
                    end
                    if (take & ~hwrite) begin
                        state_q     <= BUS_READ;
                        hreadyout_q <= 1'b0;
                    end
                end
                BUS_READ: begin
                    wr_q        <= 1'b0;
                    hrdata_q    <= addr_ok_q ? rd_mux : 32'h0000_0000;
                    hreadyout_q <= 1'b1;
                    state_q     <= BUS_IDLE;
                end
                default: begin
                    state_q     <= BUS_IDLE;
                    hreadyout_q <= 1'b1;
                end
            endcase
        end
    end

    // Global control, prescaler
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_q        <= 3'h0;
            sync_q       <= 3'h0;
            mode_q       <= 4'h0;
            presc_q      <= 3'h0;
            ext_prev_q   <= 4'h0;
            cap_a_prev_q <= 3'h0;
            cap_b_prev_q <= 3'h0;
        end else begin
            if (wr_run) run_q <= hwdata[2:0];
            if (wr_sync) sync_q <= hwdata[2:0];
            if (wr_mode) mode_q <= hwdata[3:0];
            presc_q      <= presc_q + 3'h1;
            ext_prev_q   <= ext_now;
            cap_a_prev_q <= capture_in_a;
            cap_b_prev_q <= capture_in_b;
        end
    end

    // Per-channel counter and PWM
    for (genvar g = 0; g < 3; g++) begin : g_ch
        wire [2:0]  src     = ctrl_q[g][timer_pkg::CTRL_SRC_LSB +: 3];
        wire [1:0]  edg     = ctrl_q[g][timer_pkg::CTRL_EDGE_LSB +: 2];
        wire [1:0]  clr     = ctrl_q[g][timer_pkg::CTRL_CLR_LSB +: 2];
        wire [1:0]  cape    = ctrl_q[g][timer_pkg::CTRL_CAPE_LSB +: 2];
        wire        pwm     = mode_q[g];
        wire        cap_a_m = ctrl_q[g][timer_pkg::CTRL_CAPA_BIT] & ~pwm;
        wire        cap_b_m = ctrl_q[g][timer_pkg::CTRL_CAPB_BIT] & ~pwm;
        wire        here    = wr_en & ch_hit(addr_q, g);
        wire        wr_ctrl = here & (sub == timer_pkg::SUB_CTRL);
        wire        wr_gra  = here & (sub == timer_pkg::SUB_GRA);
        wire        wr_grb  = here & (sub == timer_pkg::SUB_GRB);
        wire        quad    = phase_on & (g == 2);
        wire        ext_sel = ext_now[src[1:0]];
        wire        ext_old = ext_prev_q[src[1:0]];
        wire        ext_tk  = edge_hit(edg, ext_sel & ~ext_old, ~ext_sel & ext_old);

        // Count clock source
        wire        src_tk  = src[2] ? ext_tk :
                              (src == timer_pkg::SRC_SYS)  ? 1'b1 :
                              (src == timer_pkg::SRC_DIV2) ? presc_q[0] :
                              (src == timer_pkg::SRC_DIV4) ? (presc_q[1:0] == 2'b11) :
                                                             (presc_q == 3'b111);
        wire        tick    = run_q[g] & (quad ? (steps.step_up | steps.step_down) : src_tk); // RL9
        wire        down    = quad & steps.step_down; // RL9

        // Capture edges, inhibited in PWM mode
        wire        cap_a   = cap_a_m & edge_hit(cape, capture_in_a[g] & ~cap_a_prev_q[g],
                                                 ~capture_in_a[g] & cap_a_prev_q[g]);
        wire        cap_b   = cap_b_m & edge_hit(cape, capture_in_b[g] & ~cap_b_prev_q[g],
                                                 ~capture_in_b[g] & cap_b_prev_q[g]);

        // Match only as the counter leaves the equal value
        wire        mat_a   = tick & (cnt_q[g] == gra_q[g]) & ~cap_a_m & ~wr_gra; // RL15 RL10
        wire        mat_b   = tick & (cnt_q[g] == grb_q[g]) & ~cap_b_m & ~wr_grb; // RL15 RL10

        assign ev_a[g]      = mat_a | cap_a;
        assign ev_b[g]      = mat_b | cap_b;
        assign ev_ovf[g]    = tick & (down ? (cnt_q[g] == timer_pkg::CNT_RST)
                                           : (cnt_q[g] == timer_pkg::CNT_TOP)); // RL17
        assign own_clr[g]   = ((clr == timer_pkg::CLR_GRA) & ev_a[g])
                            | ((clr == timer_pkg::CLR_GRB) & ev_b[g]); // RL22 RL23
        assign cnt_wr_v[g]  = here & (sub == timer_pkg::SUB_CNT);

        // Clear beats write, write beats count
        wire        clr_now = own_clr[g] | ((clr == timer_pkg::CLR_SYNC) & sync_q[g] & sync_clr); // RL2
        wire        load    = cnt_wr_v[g] | (sync_q[g] & sync_wr); // RL1
        wire [15:0] step_v  = down ? (cnt_q[g] - 16'h0001) : (cnt_q[g] + 16'h0001);
        wire [15:0] cnt_d   = clr_now ? timer_pkg::CNT_RST :
                              load    ? hwdata[15:0] :
                              tick    ? step_v : cnt_q[g];

        // Capture beats register write
        wire [15:0] gra_d   = cap_a ? cnt_q[g] : wr_gra ? hwdata[15:0] : gra_q[g]; // RL16
        wire [15:0] grb_d   = cap_b ? cnt_q[g] : wr_grb ? hwdata[15:0] : grb_q[g]; // RL16

        // PWM pin: set on A, clear on B, hold when both
        assign out_d[g]     = wr_init ? hwdata[g] :                            // RL13
                              (pwm & mat_a & ~mat_b) ? 1'b1 :                  // RL3 RL4 RL7
                              (pwm & mat_b & ~mat_a) ? 1'b0 : out_q[g];        // RL3 RL5 RL6

        assign ch_rd[g]     = (sub == timer_pkg::SUB_CTRL) ? {21'h0, ctrl_q[g]} :
                              (sub == timer_pkg::SUB_CNT)  ? {16'h0, cnt_q[g]} :
                              (sub == timer_pkg::SUB_GRA)  ? {16'h0, gra_q[g]} :
                                                             {16'h0, grb_q[g]};

        // Channel state registers
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                cnt_q[g]  <= timer_pkg::CNT_RST;
                gra_q[g]  <= timer_pkg::GR_RST;
                grb_q[g]  <= timer_pkg::GR_RST;
                ctrl_q[g] <= timer_pkg::CTRL_RST;
            end else begin
                cnt_q[g]  <= cnt_d;
                gra_q[g]  <= gra_d;
                grb_q[g]  <= grb_d;
                if (wr_ctrl) ctrl_q[g] <= hwdata[10:0];
            end
        end
    end

    // Flag groups: 0 match/capture A, 1 match/capture B, 2 wrap
    for (genvar k = 0; k < 3; k++) begin : g_flag
        wire       rd_st  = rd_en & (addr_q == stat_ofs[k]);
        wire       wr_st  = wr_en & (addr_q == stat_ofs[k]);
        wire [2:0] set_v  = (k == 0) ? ev_a : (k == 1) ? ev_b : ev_ovf;
        wire [2:0] clr_v  = {3{wr_st}} & ~hwdata[2:0] & arm_q[k]; // RL18
        wire [2:0] flag_d = set_v | (flag_q[k] & ~clr_v); // RL16 RL17
        wire [2:0] arm_d  = rd_st ? (arm_q[k] | flag_q[k]) : wr_st ? 3'h0 : arm_q[k]; // RL18

        // Flag, arm and enable registers
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                flag_q[k] <= 3'h0;
                arm_q[k]  <= 3'h0;
                en_q[k]   <= 3'h0;
            end else begin
                flag_q[k] <= flag_d;
                arm_q[k]  <= arm_d;
                if (wr_st) en_q[k] <= hwdata[timer_pkg::STAT_EN_LSB +: 3];
            end
        end
    end

    // Requests by priority: channel, then A, B, wrap
    for (genvar i = 0; i < 9; i++) begin : g_req
        assign irq_d[i] = flag_q[i % 3][i / 3] & en_q[i % 3][i / 3]; // RL19 RL21
    end

    // Pin, enable and request registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_q <= 3'h0;
            oe_q  <= 3'h0;
            irq_q <= 9'h000;
            vec_q <= timer_pkg::VEC_NONE;
        end else begin
            out_q <= out_d;
            oe_q  <= mode_q[2:0]; // RL8
            irq_q <= irq_d;
            vec_q <= first_set(irq_d); // RL20
        end
    end

    assign hrdata            = hrdata_q;
    assign hreadyout         = hreadyout_q;
    assign hresp             = 1'b0;
    assign channel_out_a_pin = out_q;
    assign channel_out_a_oe  = oe_q;
    assign match_irq_a       = {irq_q[6], irq_q[3], irq_q[0]};
    assign match_irq_b       = {irq_q[7], irq_q[4], irq_q[1]};
    assign wrap_irq          = {irq_q[8], irq_q[5], irq_q[2]};
    assign irq_vector        = vec_q;

endmodule

`default_nettype wire

// file: timer_pkg.sv
package timer_pkg;

    // Channel count and widths
    localparam int          NUM_CH        = 3;
    localparam int          CNT_W         = 16;

    // Common register byte offsets
    localparam logic [7:0]  OFS_RUN       = 8'h00;
    localparam logic [7:0]  OFS_SYNC      = 8'h04;
    localparam logic [7:0]  OFS_MODE      = 8'h08;
    localparam logic [7:0]  OFS_OUT_INIT  = 8'h0c;
    localparam logic [7:0]  OFS_STAT_A    = 8'h10;
    localparam logic [7:0]  OFS_STAT_B    = 8'h14;
    localparam logic [7:0]  OFS_STAT_OVF  = 8'h18;
    localparam logic [7:0]  OFS_OUT_LVL   = 8'h1c;

    // Channel block: 16 bytes per channel, first block at 0x20
    localparam logic [3:0]  CH_BLK_FIRST  = 4'h2;
    localparam logic [1:0]  SUB_CTRL      = 2'h0;
    localparam logic [1:0]  SUB_CNT       = 2'h1;
    localparam logic [1:0]  SUB_GRA       = 2'h2;
    localparam logic [1:0]  SUB_GRB       = 2'h3;

    // Channel control, mode and status field positions
    localparam int          CTRL_W        = 11;
    localparam int          CTRL_SRC_LSB  = 0;
    localparam int          CTRL_EDGE_LSB = 3;
    localparam int          CTRL_CLR_LSB  = 5;
    localparam int          CTRL_CAPA_BIT = 7;
    localparam int          CTRL_CAPB_BIT = 8;
    localparam int          CTRL_CAPE_LSB = 9;
    localparam int          MODE_PHASE_BIT = 3;
    localparam int          STAT_EN_LSB   = 4;

    // Values after reset, and the counter top value
    localparam logic [15:0] CNT_RST       = 16'h0000;
    localparam logic [15:0] GR_RST        = 16'hffff;
    localparam logic [15:0] CNT_TOP       = 16'hffff;
    localparam logic [10:0] CTRL_RST      = 11'h000;
    localparam logic [3:0]  VEC_NONE      = 4'hf;

    // Clock source select codes
    typedef enum logic [2:0] {
        SRC_SYS   = 3'b000,
        SRC_DIV2  = 3'b001,
        SRC_DIV4  = 3'b010,
        SRC_DIV8  = 3'b011
    } clk_src_t;

    // Clear source select codes
    typedef enum logic [1:0] {
        CLR_NONE  = 2'b00,
        CLR_GRA   = 2'b01,
        CLR_GRB   = 2'b10,
        CLR_SYNC  = 2'b11
    } clr_sel_t;

    // Edge select codes: 00 rising, 01 falling, 1x both
    localparam logic [1:0]  EDGE_RISE     = 2'b00;
    localparam logic [1:0]  EDGE_FALL     = 2'b01;

endpackage

// file: phase_step_if.sv
`timescale 1ns/1ns
`default_nettype none

// One-cycle count steps from the quadrature decoder
interface phase_step_if;
    logic step_up;
    logic step_down;
    modport src (output step_up, output step_down);
    modport dst (input step_up, input step_down);
endinterface

`default_nettype wire

// file: phase_decoder.sv
`timescale 1ns/1ns
`default_nettype none

module phase_decoder (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Phase pins
    input  wire logic        phase_input_a,
    input  wire logic        phase_input_b,
    // Steps out
    phase_step_if.src        steps
);

    logic a_q;
    logic b_q;
    logic up_q;
    logic down_q;

    // Edge terms against last sampled level
    wire a_rise = phase_input_a & ~a_q;
    wire a_fall = ~phase_input_a & a_q;
    wire b_rise = phase_input_b & ~b_q;
    wire b_fall = ~phase_input_b & b_q;

    // Each edge of one pin alone gives one step; edges of both pins in one cycle give none
    wire up_d   = (b_rise & ~phase_input_a) | (a_rise & phase_input_b)
                | (b_fall & phase_input_a) | (a_fall & ~phase_input_b); // RL11 RL12
    wire down_d = (a_rise & ~phase_input_b) | (b_rise & phase_input_a)
                | (a_fall & phase_input_b) | (b_fall & ~phase_input_a); // RL11 RL12

    // Sample pins, register steps
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_q    <= 1'b0;
            b_q    <= 1'b0;
            up_q   <= 1'b0;
            down_q <= 1'b0;
        end else begin
            a_q    <= phase_input_a;
            b_q    <= phase_input_b;
            up_q   <= up_d & ~down_d;
            down_q <= down_d & ~up_d;
        end
    end

    assign steps.step_up   = up_q;
    assign steps.step_down = down_q;

endmodule

`default_nettype wire

// file: sync_pwm_timer_props.sv
`timescale 1ns/1ns
`default_nettype none

module sync_pwm_timer_props #(
    parameter int NCH = 3
) (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Pins and requests
    input wire logic [2:0]  channel_out_a_oe,
    input wire logic [2:0]  match_irq_a,
    input wire logic [2:0]  match_irq_b,
    input wire logic [2:0]  wrap_irq,
    input wire logic [3:0]  irq_vector
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic       taken;
    logic [8:0] req;
    logic [3:0] exp_vec;
    logic       rd_dp_q;
    logic       wr_dp_q;

    // Accepted transfer, requests by priority
    assign taken = hsel & htrans[1] & hready;
    for (genvar c = 0; c < 3; c++) begin : g_req
        assign req[3*c +: 3] = {wrap_irq[c], match_irq_b[c], match_irq_a[c]};
    end

    // Lowest pending index wins
    always_comb begin
        exp_vec = 4'hf;
        for (int i = 8; i >= 0; i--) begin
            if (req[i]) begin
                exp_vec = 4'(i);
            end
        end
    end

    // Data phase tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_dp_q <= 1'b0;
            wr_dp_q <= 1'b0;
        end else if (hready) begin
            rd_dp_q <= taken & ~hwrite;
            wr_dp_q <= taken & hwrite;
        end
    end

    a_resp_okay: assert property (hresp == 1'b0) else $error("slave response not OKAY");
    a_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
    a_write_nowait: assert property (taken && hwrite |=> hreadyout) else $error("write stalled");
    a_wait_cause: assert property (!hreadyout |-> rd_dp_q && $past(hreadyout)) else $error("stray wait");
    a_wait_once: assert property (!hreadyout |=> hreadyout) else $error("wait too long");
    a_rdata_hold: assert property ($changed(hrdata) |-> $past(rd_dp_q)) else $error("read data moved");
    a_oe_cause: assert property ($changed(channel_out_a_oe) |-> $past(wr_dp_q) || $past(wr_dp_q, 2))
        else $error("oe moved");
    a_vector_prio: assert property (irq_vector == exp_vec) else $error("vector wrong");
endmodule

bind sync_pwm_timer sync_pwm_timer_props #(.NCH(NCH)) i_props (.*);

`default_nettype wire

// file: quad_encoder.sv
`timescale 1ns/1ns
`default_nettype none

module quad_encoder (
    // Clock
    input  wire logic hclk,
    // Phase pins
    output var logic  phase_input_a,
    output var logic  phase_input_b
);
    logic [1:0] pos;

    // Shaft at rest
    initial begin
        pos = 2'd0;
        phase_input_a = 1'b0;
        phase_input_b = 1'b0;
    end

    // n gray steps per move, each held five clocks
    task automatic move(input logic up, input int n);
        repeat (n) begin
            @(posedge hclk);
            pos = up ? pos + 2'd1 : pos - 2'd1;
            phase_input_a <= pos[1];
            phase_input_b <= pos[1] ^ pos[0];
            repeat (4) @(posedge hclk);
        end
    endtask
endmodule

`default_nettype wire

// file: three_channel_timer_sync_pwm_phase_test.sv
`timescale 1ns/1ns
`default_nettype none

module three_channel_timer_sync_pwm_phase_test;
    // Clock, reset and bus
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    // Pins and requests
    logic        ph_a;
    logic        ph_b;
    logic [2:0]  pin;
    logic [2:0]  oe;
    logic [2:0]  irq_a;
    logic [2:0]  irq_b;
    logic [2:0]  irq_w;
    logic [3:0]  vec;
    logic [31:0] rd;
    int          err_count;
    int          tests_run;
    // Duty: init, ctrl, a, b, highs
    localparam int TAB [4][5] = '{'{0, 'h40, 7, 3, 0}, '{0, 'h20, 3, 7, 60}, '{2, 'h20, 3, 3, 60}, '{0, 'h20, 3, 3, 0}};

    sync_pwm_timer i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .phase_input_a(ph_a), .phase_input_b(ph_b), .ext_clk_in(2'b00),
        .capture_in_a(3'b000), .capture_in_b(3'b000), .channel_out_a_pin(pin), .channel_out_a_oe(oe),
        .match_irq_a(irq_a), .match_irq_b(irq_b), .wrap_irq(irq_w), .irq_vector(vec)
    );
    quad_encoder i_enc (.hclk(hclk), .phase_input_a(ph_a), .phase_input_b(ph_b));

    // 50 MHz clock
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One word transfer
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask

    function automatic logic [7:0] chreg(input logic [3:0] g, input logic [1:0] sub);
        return {timer_pkg::CH_BLK_FIRST + g, sub, 2'b00};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    // High cycles in sixty clocks
    task automatic high_count(input int ch, output int n);
        n = 0;
        repeat (60) begin
            @(negedge hclk);
            n += (pin[ch] === 1'b1);
        end
    endtask

    task automatic t_reset_map();
        rchk("gra", chreg(0, timer_pkg::SUB_GRA), 32'h0000ffff);
        wr(8'h50, 32'h1234);
        rchk("unmapped", 8'h50, 32'h0);
        check("vector", {28'h0, vec}, 32'hf);
        $display("test reset_map done");
    endtask

    task automatic t_sync_pwm();
        int n;
        wr(timer_pkg::OFS_SYNC, 32'h3);
        wr(chreg(0, timer_pkg::SUB_CNT), 32'h0abc);
        rchk("cnt1", chreg(1, timer_pkg::SUB_CNT), 32'h0abc);
        rchk("cnt2", chreg(2, timer_pkg::SUB_CNT), 32'h0);
        wr(chreg(0, timer_pkg::SUB_CNT), 32'h0);
        wr(chreg(0, timer_pkg::SUB_GRA), 32'h1);
        wr(chreg(0, timer_pkg::SUB_GRB), 32'h5);
        wr(chreg(0, timer_pkg::SUB_CTRL), 32'h40);
        wr(chreg(1, timer_pkg::SUB_GRA), 32'h3);
        wr(chreg(1, timer_pkg::SUB_GRB), 32'h4);
        wr(chreg(1, timer_pkg::SUB_CTRL), 32'h60);
        wr(timer_pkg::OFS_MODE, 32'h3);
        wr(timer_pkg::OFS_RUN, 32'h3);
        check("oe", {29'h0, oe}, 32'h3);
        repeat (12) @(posedge hclk);
        high_count(0, n);
        check("ch0 high", n, 40);
        high_count(1, n);
        check("ch1 high", n, 10);
        wr(timer_pkg::OFS_RUN, 32'h0);
        wr(timer_pkg::OFS_SYNC, 32'h0);
        $display("test sync_pwm done");
    endtask

    task automatic t_duty();
        int n;
        foreach (TAB[i]) begin
            wr(timer_pkg::OFS_RUN, 32'h0);
            wr(timer_pkg::OFS_OUT_INIT, TAB[i][0]);
            wr(chreg(1, timer_pkg::SUB_CNT), 32'h0);
            wr(chreg(1, timer_pkg::SUB_GRA), TAB[i][2]);
            wr(chreg(1, timer_pkg::SUB_GRB), TAB[i][3]);
            wr(chreg(1, timer_pkg::SUB_CTRL), TAB[i][1]);
            wr(timer_pkg::OFS_RUN, 32'h2);
            repeat (12) @(posedge hclk);
            high_count(1, n);
            check("duty", n, TAB[i][4]);
        end
        wr(timer_pkg::OFS_RUN, 32'h0);
        $display("test duty done");
    endtask

    task automatic t_phase();
        wr(timer_pkg::OFS_MODE, 32'h8);
        wr(chreg(2, timer_pkg::SUB_CNT), 32'h0);
        wr(timer_pkg::OFS_STAT_OVF, 32'h40);
        wr(timer_pkg::OFS_RUN, 32'h4);
        i_enc.move(1'b0, 1);
        repeat (8) @(posedge hclk);
        rchk("down", chreg(2, timer_pkg::SUB_CNT), 32'hffff);
        check("wrap irq", {29'h0, irq_w}, 32'h4);
        check("vector", {28'h0, vec}, 32'h8);
        rchk("wrap flag", timer_pkg::OFS_STAT_OVF, 32'h44);
        wr(timer_pkg::OFS_STAT_OVF, 32'h44);
        wr(timer_pkg::OFS_STAT_OVF, 32'h40);
        rchk("flag kept", timer_pkg::OFS_STAT_OVF, 32'h44);
        wr(timer_pkg::OFS_STAT_OVF, 32'h40);
        rchk("flag clear", timer_pkg::OFS_STAT_OVF, 32'h40);
        check("irq off", {29'h0, irq_w}, 32'h0);
        i_enc.move(1'b1, 5);
        repeat (8) @(posedge hclk);
        rchk("up", chreg(2, timer_pkg::SUB_CNT), 32'h4);
        rchk("wrap up", timer_pkg::OFS_STAT_OVF, 32'h44);
        $display("test phase done");
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Reset, then the scenarios
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        err_count = 0;
        tests_run = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset_map();
        t_sync_pwm();
        t_duty();
        t_phase();
        report_and_stop();
    end

    // Hang guard
    initial begin
        #200000;
        err_count++;
        report_and_stop();
    end
endmodule

`default_nettype wire
